// file: logic/pcs_pkg.sv
package pcs_pkg;

	// configuration offsets of the registers held here
	localparam logic [7:0] OFS_STATUS = 8'h06;
	localparam logic [7:0] OFS_REVISION = 8'h08;
	localparam logic [7:0] OFS_PROG_IF = 8'h09;

	// dword index of a configuration offset
	localparam int DW_LSB = 2;

	// status field positions
	localparam int STA_BIT = 11;
	localparam int TIMING_HI = 10;
	localparam int TIMING_LO = 9;
	localparam int DPR_BIT = 8;
	localparam int B2B_BIT = 7;
	localparam int CAP_BIT = 4;

	// status sits in the upper half of its dword
	localparam int STATUS_SHIFT = 16;
	localparam int STATUS_LANE = 3;
	localparam int STATUS_W = 16;

	// timing class codes, medium is the one this target uses
	localparam logic [1:0] TIMING_FAST = 2'h0;
	localparam logic [1:0] TIMING_MEDIUM = 2'h1;
	localparam logic [1:0] TIMING_SLOW = 2'h2;

	// fixed field values
	localparam logic [7:0] PROG_IF_VALUE = 8'h00;
	localparam logic BIT_ONE = 1'b1;
	localparam logic [3:0] BE_NONE = 4'h0;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
	localparam logic [15:0] STATUS_ZERO = 16'h0000;

	// address space of a target access
	typedef enum logic [1:0]
	{
		SP_CFG = 2'b00,
		SP_DEV = 2'b01,
		SP_ROM = 2'b10,
		SP_CBRAM = 2'b11
	} pcs_space_e;

	// transaction state
	typedef enum logic
	{
		ST_IDLE = 1'b0,
		ST_CLAIM = 1'b1
	} pcs_state_e;

	// one decoded target access, valid in its address phase
	typedef struct packed
	{
		logic valid;
		logic write;
		pcs_space_e space;
		logic host_only;
		logic [3:0] be;
		logic [7:0] offset;
		logic [31:0] wdata;
		logic addr_perr;
		logic addr_match;
	} pcs_req_s;

	// device state that steers the abort decision
	typedef struct packed
	{
		logic [31:0] io_base_window;
		logic [31:0] option_rom_base;
		logic option_rom_decode_enable;
		logic serial_rom_access_mode;
		logic power_down_control;
		logic seq_paused;
		logic serr_active;
	} pcs_ctl_s;

	// target answer
	typedef struct packed
	{
		logic devsel;
		logic abort;
		logic done;
		logic [31:0] rdata;
	} pcs_rsp_s;

	// device register spaces, the control-block ram among them
	function automatic logic is_dev_space(input pcs_space_e sp);
		is_dev_space = (sp == SP_DEV) || (sp == SP_CBRAM);
	endfunction : is_dev_space

endpackage : pcs_pkg

// file: logic/pcs_abort_check.sv
`timescale 1ns/10ps
`default_nettype none

// decides in the address phase whether an access is target-aborted
module pcs_abort_check
(
	input var pcs_pkg::pcs_req_s req,
	input var pcs_pkg::pcs_ctl_s ctl,
	output logic abort
);

	// exactly one byte lane active
	function automatic logic one_byte(input logic [3:0] be);
		one_byte = (be != pcs_pkg::BE_NONE) && ((be & (be - 4'h1)) == pcs_pkg::BE_NONE);
	endfunction : one_byte

	logic no_lanes; // empty data phase, legal
	logic bad_width;
	logic alias_hit;
	logic serial_hit;
	logic pdown_hit;
	logic perr_hit;
	logic seq_hit;

	// each abort cause on its own
	always_comb
	begin
		no_lanes = (req.be == pcs_pkg::BE_NONE);
		// device access or rom write wider than one byte
		bad_width = !no_lanes && !one_byte(req.be)
			&& (pcs_pkg::is_dev_space(req.space)
			|| (req.space == pcs_pkg::SP_ROM && req.write));
		// io window and rom window collide while rom decodes
		alias_hit = (req.space != pcs_pkg::SP_CFG) && ctl.option_rom_decode_enable
			&& (ctl.io_base_window == ctl.option_rom_base);
		// control-block ram locked out in serial rom mode
		serial_hit = ctl.serial_rom_access_mode && (req.space == pcs_pkg::SP_CBRAM);
		// power down leaves only host-only and config registers
		pdown_hit = ctl.power_down_control && (req.space != pcs_pkg::SP_CFG)
			&& !req.host_only;
		// address parity error on our own address with system error raised
		perr_hit = req.addr_perr && req.addr_match && ctl.serr_active;
		// device registers other than host-only ones need the sequencer paused
		seq_hit = pcs_pkg::is_dev_space(req.space) && !req.host_only
			&& !ctl.seq_paused;
		abort = bad_width || alias_hit || serial_hit || pdown_hit || perr_hit || seq_hit;
	end

endmodule : pcs_abort_check

`default_nettype wire

// file: logic/pcs_cfg_status.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - abort device access or rom write not one byte
// - abort when io and rom bases alias, rom on
// - abort control-block ram access in serial rom mode
// - power down aborts all but host-only and config
// - abort on own address parity error with serr
// - abort device registers while sequencer runs, host-only excepted
// - empty byte enables are legal, never aborted for width
// - status bits 10:9 read fixed medium timing
// - claim with devsel on second clock
// - set bit 8 on master parity report
// - bit 8 cleared by reset or write one
// - bit 7 reads one, back-to-back accepted
// - bit 4 reads one, capability list present
// - revision byte read-only, per silicon revision
// - programming interface byte always reads zero
// - revision readable at any time except on an address parity abort
// - bit 11 set on abort, write-one clears
module pcs_cfg_status
#(
	// revision code, value arbitrary
	parameter logic [7:0] REVISION = 8'h03
)
(
	input wire logic clk,
	input wire logic rst,
	input var pcs_pkg::pcs_req_s req,
	input var pcs_pkg::pcs_ctl_s ctl,
	input wire logic parity_response_enable,
	input wire logic master_perr_event,
	output pcs_pkg::pcs_rsp_s rsp,
	output logic [15:0] status_o
);

	// transaction state
	pcs_pkg::pcs_state_e state_ff;
	pcs_pkg::pcs_state_e nxt_state;

	// sticky status flags
	logic sta_ff;
	logic nxt_sta;
	logic dpr_ff;
	logic nxt_dpr;

	// answer held for the claim cycle
	logic abort_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;

	// address phase decode
	logic taken; // access accepted this cycle
	logic abort_now; // abort decision for it
	logic cfg_access; // configuration space access
	logic status_wr; // write reaching the status half
	logic dpr_clr; // write one to bit 8
	logic sta_clr; // write one to bit 11
	logic dpr_set; // master parity event

	// abort decision, purely combinational
	pcs_abort_check u_check
	(
		.req(req),
		.ctl(ctl),
		.abort(abort_now)
	);

	// decode of the incoming access
	always_comb
	begin
		// always ready, so fast back-to-back accesses are taken as they come
		taken = req.valid;
		cfg_access = (req.space == pcs_pkg::SP_CFG);
		// an aborted write does not reach the status register
		status_wr = taken && req.write && cfg_access && !abort_now
			&& (req.offset[7:pcs_pkg::DW_LSB] == pcs_pkg::OFS_STATUS[7:pcs_pkg::DW_LSB])
			&& req.be[pcs_pkg::STATUS_LANE];
		dpr_clr = status_wr && req.wdata[pcs_pkg::STATUS_SHIFT + pcs_pkg::DPR_BIT];
		sta_clr = status_wr && req.wdata[pcs_pkg::STATUS_SHIFT + pcs_pkg::STA_BIT];
		// only reported when parity response is enabled
		dpr_set = parity_response_enable && master_perr_event;
	end

	// next state: claim one clock after the address phase
	always_comb
	begin
		nxt_state = pcs_pkg::ST_IDLE;
		if (taken)
		begin
			// medium decode, devsel on the second clock
			nxt_state = pcs_pkg::ST_CLAIM;
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= pcs_pkg::ST_IDLE;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// target-abort flag: a set in the same cycle beats the clear
	always_comb
	begin
		nxt_sta = sta_ff;
		if (taken && abort_now)
		begin
			// set wins over a simultaneous write one
			nxt_sta = 1'b1;
		end
		else if (sta_clr)
		begin
			nxt_sta = 1'b0;
		end
	end

	// parity reported flag: a set in the same cycle beats the clear
	always_comb
	begin
		nxt_dpr = dpr_ff;
		if (dpr_set)
		begin
			nxt_dpr = 1'b1;
		end
		else if (dpr_clr)
		begin
			// write one clears, write zero leaves it
			nxt_dpr = 1'b0;
		end
	end

	// sticky flags, both clear under reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sta_ff <= 1'b0;
			dpr_ff <= 1'b0;
		end
		else
		begin
			sta_ff <= nxt_sta;
			dpr_ff <= nxt_dpr;
		end
	end

	// status half as read by the host
	always_comb
	begin
		// bits 6, 5 and 3:0 and the unheld upper bits stay zero
		status_o = pcs_pkg::STATUS_ZERO;
		status_o[pcs_pkg::STA_BIT] = sta_ff;
		// fixed timing class, read only
		status_o[pcs_pkg::TIMING_HI:pcs_pkg::TIMING_LO] = pcs_pkg::TIMING_MEDIUM;
		status_o[pcs_pkg::DPR_BIT] = dpr_ff;
		status_o[pcs_pkg::B2B_BIT] = pcs_pkg::BIT_ONE;
		status_o[pcs_pkg::CAP_BIT] = pcs_pkg::BIT_ONE;
	end

	// read data of the accepted access
	always_comb
	begin
		nxt_rdata = pcs_pkg::DATA_ZERO;
		if (taken && !req.write && cfg_access && !abort_now)
		begin
			if (req.offset[7:pcs_pkg::DW_LSB] == pcs_pkg::OFS_STATUS[7:pcs_pkg::DW_LSB])
			begin
				// status in the upper half, command lives elsewhere
				nxt_rdata[pcs_pkg::STATUS_SHIFT +: pcs_pkg::STATUS_W] = status_o;
			end
			else if (req.offset[7:pcs_pkg::DW_LSB]
				== pcs_pkg::OFS_REVISION[7:pcs_pkg::DW_LSB])
			begin
				// revision is gated only by an address parity abort, not by power down or the sequencer
				nxt_rdata[8*pcs_pkg::OFS_REVISION[1:0] +: 8] = REVISION;
				nxt_rdata[8*pcs_pkg::OFS_PROG_IF[1:0] +: 8] = pcs_pkg::PROG_IF_VALUE;
			end
		end
	end

	// answer registers, loaded on every accepted access
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			abort_ff <= 1'b0;
			rdata_ff <= pcs_pkg::DATA_ZERO;
		end
		else if (taken)
		begin
			abort_ff <= abort_now;
			rdata_ff <= nxt_rdata;
		end
	end

	// handshake outputs during the claim cycle
	always_comb
	begin
		rsp.devsel = (state_ff == pcs_pkg::ST_CLAIM);
		rsp.abort = (state_ff == pcs_pkg::ST_CLAIM) && abort_ff;
		// an empty data phase still completes normally
		rsp.done = (state_ff == pcs_pkg::ST_CLAIM) && !abort_ff;
		rsp.rdata = rdata_ff;
	end

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// an access taken, then claimed on the next clock
	sequence s_taken;
		req.valid;
	endsequence

	sequence s_claimed;
		rsp.devsel ##0 (rsp.abort != rsp.done);
	endsequence

	sequence s_aborted;
		rsp.devsel ##0 rsp.abort ##0 status_o[pcs_pkg::STA_BIT];
	endsequence

	width_abort_a: assert property (
		(req.valid && pcs_pkg::is_dev_space(req.space) && req.be != pcs_pkg::BE_NONE
		&& !$onehot(req.be)) |=> s_aborted)
	else $error("wide device access not aborted");

	rom_alias_a: assert property (
		(req.valid && req.space != pcs_pkg::SP_CFG && ctl.option_rom_decode_enable
		&& ctl.io_base_window == ctl.option_rom_base) |=> s_aborted)
	else $error("rom and io alias not aborted");

	serial_mode_a: assert property (
		(req.valid && ctl.serial_rom_access_mode && req.space == pcs_pkg::SP_CBRAM)
		|=> rsp.abort)
	else $error("control-block ram access in serial mode not aborted");

	power_down_a: assert property (
		(req.valid && ctl.power_down_control && req.space != pcs_pkg::SP_CFG
		&& !req.host_only) |=> rsp.abort)
	else $error("access during power down not aborted");

	addr_parity_a: assert property (
		(req.valid && req.addr_perr && req.addr_match && ctl.serr_active)
		|=> rsp.abort)
	else $error("address parity error not aborted");

	seq_running_a: assert property (
		(req.valid && req.space == pcs_pkg::SP_DEV && !req.host_only
		&& !ctl.seq_paused) |=> rsp.abort)
	else $error("device access while sequencer runs not aborted");

	empty_lanes_a: assert property (
		(req.valid && req.space == pcs_pkg::SP_CFG && req.be == pcs_pkg::BE_NONE
		&& !req.addr_perr) |=> rsp.done)
	else $error("empty data phase was aborted");

	fixed_bits_a: assert property (
		status_o[pcs_pkg::TIMING_HI:pcs_pkg::TIMING_LO] == pcs_pkg::TIMING_MEDIUM
		&& status_o[pcs_pkg::B2B_BIT] && status_o[pcs_pkg::CAP_BIT]
		&& status_o[6:5] == 2'h0 && status_o[3:0] == 4'h0)
	else $error("fixed status bits wrong");

	devsel_medium_a: assert property (
		s_taken |=> s_claimed)
	else $error("devsel not on second clock");

	devsel_only_a: assert property (
		!$past(req.valid) |-> !rsp.devsel)
	else $error("devsel without an access");

	dpr_set_a: assert property (
		(parity_response_enable && master_perr_event) |=> status_o[pcs_pkg::DPR_BIT])
	else $error("parity report not recorded");

	dpr_clear_a: assert property (
		(dpr_clr && !dpr_set) |=> !status_o[pcs_pkg::DPR_BIT])
	else $error("write one did not clear bit 8");

	dpr_hold_a: assert property (
		(status_o[pcs_pkg::DPR_BIT] && !dpr_clr) |=> status_o[pcs_pkg::DPR_BIT])
	else $error("bit 8 lost without a write one");

	sta_clear_a: assert property (
		(sta_clr && !(req.valid && abort_now)) |=> !status_o[pcs_pkg::STA_BIT])
	else $error("write one did not clear bit 11");

	revision_read_a: assert property (
		(req.valid && !req.write && req.space == pcs_pkg::SP_CFG && !req.addr_perr
		&& req.offset[7:pcs_pkg::DW_LSB] == pcs_pkg::OFS_REVISION[7:pcs_pkg::DW_LSB])
		|=> rsp.done && rsp.rdata[7:0] == REVISION && rsp.rdata[15:8] == 8'h00)
	else $error("revision read wrong");

	// rom writes, the abort flag itself and the answer around a claim
	rom_width_a: assert property (
		(req.valid && req.space == pcs_pkg::SP_ROM && req.write
		&& req.be != pcs_pkg::BE_NONE && !$onehot(req.be)) |=> s_aborted)
	else $error("wide rom write not aborted");

	abort_flag_a: assert property (
		(req.valid && abort_now) |=> status_o[pcs_pkg::STA_BIT])
	else $error("target abort not recorded");

	abort_hold_a: assert property (
		(status_o[pcs_pkg::STA_BIT] && !sta_clr) |=> status_o[pcs_pkg::STA_BIT])
	else $error("bit 11 lost without a write one");

	answer_idle_a: assert property (
		!rsp.devsel |-> !rsp.abort && !rsp.done)
	else $error("answer without a claim");

	empty_device_a: assert property (
		(req.valid && req.space == pcs_pkg::SP_DEV && req.host_only
		&& req.be == pcs_pkg::BE_NONE && !req.addr_perr
		&& !ctl.option_rom_decode_enable) |=> rsp.done)
	else $error("empty device data phase was aborted");

	status_read_a: assert property (
		(req.valid && !req.write && req.space == pcs_pkg::SP_CFG && !req.addr_perr
		&& req.offset[7:pcs_pkg::DW_LSB] == pcs_pkg::OFS_STATUS[7:pcs_pkg::DW_LSB])
		|=> rsp.done && rsp.rdata[pcs_pkg::STATUS_SHIFT + pcs_pkg::TIMING_LO +: 2]
		== pcs_pkg::TIMING_MEDIUM && rsp.rdata[pcs_pkg::STATUS_SHIFT + pcs_pkg::B2B_BIT]
		&& rsp.rdata[pcs_pkg::STATUS_SHIFT + pcs_pkg::CAP_BIT])
	else $error("status read wrong");

	prog_if_read_a: assert property (
		(req.valid && !req.write && req.space == pcs_pkg::SP_CFG && !req.addr_perr
		&& req.offset == pcs_pkg::OFS_PROG_IF)
		|=> rsp.rdata[8*pcs_pkg::OFS_PROG_IF[1:0] +: 8] == pcs_pkg::PROG_IF_VALUE)
	else $error("programming interface read wrong");

	// read data only moves when an access is taken
	rdata_hold_a: assert property (
		!$past(req.valid) |-> $stable(rsp.rdata))
	else $error("read data changed without an access");

endmodule : pcs_cfg_status

`default_nettype wire

// file: tb/pcs_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// host bridge side: puts one access on the bus per address phase
module pcs_host_model
(
	output var pcs_pkg::pcs_req_s req
);
	// bus starts idle
	initial req = '0;

	// called just after a rising edge; an idle phase drives inverted junk
	task automatic drive(input pcs_pkg::pcs_req_s r);
		pcs_pkg::pcs_req_s idle;
		idle = ~req;
		idle.valid = 1'b0;
		if (r.valid)
			req <= r;
		else
			req <= idle;
	endtask : drive
endmodule : pcs_host_model

`default_nettype wire

// file: tb/test_pcs_cfg_status.sv
`timescale 1ns/10ps
`default_nettype none

// self-checking bench for the status and identity block
module test_pcs_cfg_status;
	localparam logic [7:0] REV = 8'h05; // revision code, value arbitrary
	logic clk; // 200 MHz clock
	logic rst; // async reset
	pcs_pkg::pcs_req_s req; // access from host model
	pcs_pkg::pcs_ctl_s ctl; // device state
	logic pre; // parity response enable
	logic perr; // master parity event
	pcs_pkg::pcs_rsp_s rsp; // target answer
	logic [15:0] status; // status half
	logic [31:0] seed; // random state
	pcs_pkg::pcs_req_s pr; // access taken at the last edge
	pcs_pkg::pcs_ctl_s pc; // its device state
	logic [1:0] ppp; // its parity inputs
	pcs_pkg::pcs_req_s r; // scratch access
	pcs_pkg::pcs_ctl_s c; // scratch state
	logic [0:0] st11; // model of bit 11
	logic [0:0] st8; // model of bit 8
	int mismatches;
	int n_checks;

	pcs_host_model host (.req(req));
	pcs_cfg_status #(.REVISION(REV)) uut (.clk(clk), .rst(rst), .req(req), .ctl(ctl),
		.parity_response_enable(pre), .master_perr_event(perr), .rsp(rsp), .status_o(status));

	// clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// watchdog
	initial
	begin
		#20000;
		mismatches++;
		end_of_test();
	end

	// advance the random source one word
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		logic [31:0] v;
		v = s;
		for (int i = 0; i < 32; i++)
			v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
		lfsr = v;
	endfunction : lfsr

	// expected abort from the access and device state
	function automatic logic exp_abort(input pcs_pkg::pcs_req_s a, input pcs_pkg::pcs_ctl_s s);
		logic dev;
		logic cfg;
		dev = a.space == pcs_pkg::SP_DEV || a.space == pcs_pkg::SP_CBRAM;
		cfg = a.space == pcs_pkg::SP_CFG;
		exp_abort = (a.be != 4'h0 && (a.be & (a.be - 4'h1)) != 4'h0
			&& (dev || (a.space == pcs_pkg::SP_ROM && a.write)))
			|| (!cfg && s.option_rom_decode_enable
			&& s.io_base_window == s.option_rom_base)
			|| (s.serial_rom_access_mode && a.space == pcs_pkg::SP_CBRAM)
			|| (s.power_down_control && !cfg && !a.host_only)
			|| (a.addr_perr && a.addr_match && s.serr_active)
			|| (dev && !a.host_only && !s.seq_paused);
	endfunction : exp_abort

	// compare and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk

	// verdict
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	// drive one address phase, then check the answer to the previous one
	task automatic step(input pcs_pkg::pcs_req_s a, input pcs_pkg::pcs_ctl_s s,
		input logic [1:0] pp);
		logic ab;
		logic rd;
		logic [15:0] sb;
		logic [15:0] sa;
		@(posedge clk);
		host.drive(a);
		ctl <= s;
		{pre, perr} <= pp;
		@(negedge clk);
		ab = pr.valid && exp_abort(pr, pc);
		rd = pr.valid && !ab && !pr.write;
		// status as it stood when the previous access was taken
		sb = {4'h0, st11, pcs_pkg::TIMING_MEDIUM, st8, 8'h90};
		if (ab)
			st11 = 1'b1;
		else if (pr.valid && pr.write && pr.space == pcs_pkg::SP_CFG
			&& pr.offset[7:2] == 6'h01 && pr.be[3])
		begin
			// write one clears, a set in the same cycle wins
			if (pr.wdata[27])
				st11 = 1'b0;
			if (pr.wdata[24])
				st8 = 1'b0;
		end
		if (ppp == 2'b11)
			st8 = 1'b1;
		sa = {4'h0, st11, pcs_pkg::TIMING_MEDIUM, st8, 8'h90};
		chk(rsp.devsel, pr.valid, "claim");
		chk(rsp.abort, ab, "abort");
		chk(rsp.done, pr.valid && !ab, "done");
		chk(status, sa, "status");
		if (rd && pr.space == pcs_pkg::SP_CFG && pr.offset[7:2] == 6'h02)
			chk(rsp.rdata, {16'h0000, pcs_pkg::PROG_IF_VALUE, REV}, "ident");
		if (rd && pr.space == pcs_pkg::SP_CFG && pr.offset[7:2] == 6'h01)
			chk(rsp.rdata, {sb, 16'h0000}, "status read");
		if (rd && pr.space != pcs_pkg::SP_CFG)
			chk(rsp.rdata, 32'h0000_0000, "no data");
		pr = a;
		pc = s;
		ppp = pp;
	endtask : step

	// build a plain access
	function automatic pcs_pkg::pcs_req_s mk(input pcs_pkg::pcs_space_e sp, input logic wr,
		input logic [7:0] ofs, input logic [31:0] wd);
		mk = '0;
		mk.valid = 1'b1;
		mk.write = wr;
		mk.space = sp;
		mk.be = 4'hf;
		mk.offset = ofs;
		mk.wdata = wd;
	endfunction : mk

	// main sequence
	initial
	begin
		rst = 1'b1;
		ctl = '0;
		pre = 1'b0;
		perr = 1'b0;
		seed = 32'h81a3;
		{pr, pc, ppp, st11, st8, mismatches, n_checks} = '0;
		c = '0;
		c.seq_paused = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk(status, 16'h0290, "reset status");
		$display("test reset done");
		// identity reads while powered down and sequencer running
		r = '0;
		c.power_down_control = 1'b1;
		c.seq_paused = 1'b0;
		step(mk(pcs_pkg::SP_CFG, 1'b0, 8'h08, 32'h0000_0000), c, 2'b00);
		step(mk(pcs_pkg::SP_CFG, 1'b0, 8'h09, 32'h0000_0000), c, 2'b00);
		$display("test ident done");
		// parity reported flag: enable gates, zero write keeps, one write clears
		step(r, c, 2'b01);
		step(r, c, 2'b11);
		step(mk(pcs_pkg::SP_CFG, 1'b1, 8'h06, 32'h0000_0000), c, 2'b00);
		step(mk(pcs_pkg::SP_CFG, 1'b1, 8'h06, 32'hfeff_ffff), c, 2'b00);
		step(mk(pcs_pkg::SP_CFG, 1'b1, 8'h06, 32'h0100_0000), c, 2'b11);
		step(mk(pcs_pkg::SP_CFG, 1'b1, 8'h06, 32'h0100_0000), c, 2'b00);
		$display("test parity flag done");
		// random back-to-back accesses
		repeat (300)
		begin
			seed = lfsr(seed);
			r.valid = |seed[2:0];
			r.write = seed[3];
			r.space = pcs_pkg::pcs_space_e'(seed[5:4]);
			r.host_only = seed[6];
			r.be = seed[10:7];
			r.offset = {5'h00, seed[13:11]} + 8'h04;
			r.wdata = seed;
			r.addr_perr = seed[14] & seed[15];
			r.addr_match = seed[16];
			seed = lfsr(seed);
			c.io_base_window = 32'h0000_1000;
			c.option_rom_base = seed[0] ? 32'h0000_1000 : 32'h0000_2000;
			c.option_rom_decode_enable = seed[1];
			c.serial_rom_access_mode = seed[2] & seed[3];
			c.power_down_control = seed[4] & seed[5];
			c.seq_paused = seed[6] | seed[7];
			c.serr_active = seed[8];
			step(r, c, {1'b1, seed[9]});
		end
		r = '0;
		step(r, c, 2'b11);
		step(r, c, 2'b00);
		$display("test random done");
		// reset in mid-run clears both flags, then service resumes
		@(posedge clk);
		rst <= 1'b1;
		@(negedge clk);
		chk(status, 16'h0290, "reset clear");
		chk(rsp.devsel, 1'b0, "reset claim");
		@(posedge clk);
		rst <= 1'b0;
		{pr, ppp, st11, st8} = '0;
		step(mk(pcs_pkg::SP_CFG, 1'b0, 8'h08, 32'h0000_0000), c, 2'b00);
		step(r, c, 2'b00);
		$display("test second reset done");
		end_of_test();
	end
endmodule : test_pcs_cfg_status

`default_nettype wire
